// ---- src/uvfr_regs.svh ----
// Constants for the undervoltage fault response block.
// Assumes a 100 MHz core clock and byte-wide command access.
`ifndef UVFR_REGS_SVH
`define UVFR_REGS_SVH
`define UVFR_RESP_OFFSET 8'h45
`define UVFR_BIT_RSVD 7
`define UVFR_BIT_ACT 6
`define UVFR_RS_HI 5
`define UVFR_RS_LO 3
`define UVFR_TD_HI 2
`define UVFR_TD_LO 0
`define UVFR_RESP_RESET 8'h40
`define UVFR_RS_LATCH 3'h0
`define UVFR_RS_HICCUP 3'h7
`define UVFR_CLK_MHZ 100
`define UVFR_HICCUP_MS 52
`define UVFR_HICCUP_CYC (`UVFR_HICCUP_MS * 1000 * `UVFR_CLK_MHZ)
`define UVFR_TD0_US 2
`define UVFR_TD1_US 16
`define UVFR_TD2_US 64
`define UVFR_TD3_US 256
`define UVFR_US_CYC(u) ((u) * `UVFR_CLK_MHZ)
`endif

// ---- src/uvfr_pkg.sv ----
// Types for the undervoltage fault response block.
// Assumes the constants header is included alongside.
package uvfr_pkg;
	typedef enum logic [1:0] {
		UVFR_RUN   = 2'h0,
		UVFR_DELAY = 2'h1,
		UVFR_OFF   = 2'h3,
		UVFR_WAIT  = 2'h2
	} uvfr_state_type;
endpackage

// ---- src/uvfr_core.sv ----
// Undervoltage fault response controller with its response register.
// Assumes a command decoder that presents byte writes and reads, a
// comparator giving the raw undervoltage level, and a soft-start done flag.
//
// How it works
// - Fault judged by outside comparator against separate threshold.
// - Fault sets status byte, status word and output status flags, plus alert.
// - Bit 7 reads zero; writing one gets a NACK and invalid data.
// - Ignore control bit 6 resets to one; zero means keep converting.
// - With control one, wait delay, then apply retry if fault persists.
// - Uncleared fault from ignore time is acted on when control becomes one.
// - Retry 000 latches off until faults cleared or enable toggled.
// - Retry 111 restarts after 52 ms, indefinitely.
// - Retry values other than 000 or 111 are rejected as invalid data.
// - Hiccup wait is always 52 ms regardless of response delay.
// - Fault vanishing during delay with none pending from ignore time resets counter, output stays enabled.
// - Bit 2 of delay reads zero; writing one is silently dropped.
// - Delay codes select 2, 16, 64 or 256 microseconds.
// - Detection is armed only after soft-start completes.
`timescale 1ns/1ps
`include "uvfr_regs.svh"

module uvfr_core #(
	parameter int unsigned HICCUP_CYC = `UVFR_HICCUP_CYC
) (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       arst_n,
	// Command port
	input  wire logic [7:0] cmd_code,
	input  wire logic       wr_strobe,
	input  wire logic [7:0] wr_data,
	output logic [7:0]      rd_data,
	output logic            wr_nack,
	output logic            invalid_data,
	// Converter side
	input  wire logic       uv_raw,
	input  wire logic       ramp_done_raw,
	input  wire logic       enable_raw,
	input  wire logic       clear_faults,
	output logic            convert_en,
	// Status, alert and NVM retry bit
	output logic            status_byte_uv,
	output logic            output_fault_warning_flag,
	output logic            undervoltage_fault_flag,
	output logic            host_alert_pin_n,
	output logic            nvm_retry_bit
);
	import uvfr_pkg::*;

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	// uv_raw, ramp_done_raw and enable_raw each pass two flops before any logic reads them; clear_faults is not synchronised
	localparam int unsigned PINS     = 3;
	localparam int unsigned PIN_UV   = 0;
	localparam int unsigned PIN_RAMP = 1;
	localparam int unsigned PIN_EN   = 2;

	wire logic [PINS-1:0] pin_raw = {enable_raw, ramp_done_raw, uv_raw};
	logic [1:0]           sync_q [PINS];

	genvar g;
	generate
		for (g = 0; g < PINS; g = g + 1) begin : g_sync
			always_ff @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					sync_q[g] <= 2'h0;
				end else begin
					sync_q[g] <= {sync_q[g][0], pin_raw[g]};
				end
			end
		end
	endgenerate

	wire logic uv_sync   = sync_q[PIN_UV][1];
	wire logic ramp_sync = sync_q[PIN_RAMP][1];
	wire logic en_sync   = sync_q[PIN_EN][1];

	// Only the second stage is read; the first may still be settling
	logic en_prev_q;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			en_prev_q <= 1'b0;
		end else begin
			en_prev_q <= en_sync;
		end
	end

	// Detection stays blind until soft start is done
	wire logic uv_now    = uv_sync & ramp_sync;
	// A rise just after reset is harmless: only latch-off listens
	wire logic en_rise   = en_sync & ~en_prev_q;

	////////////////////////////////////////////////////////////////////
	// Response register
	logic       act_q;
	logic [2:0] rs_q;
	logic [1:0] td_q;
	wire logic       hit_resp = (cmd_code == `UVFR_RESP_OFFSET);
	wire logic       hit      = wr_strobe && hit_resp;
	wire logic       wr_act   = wr_data[`UVFR_BIT_ACT];
	wire logic [2:0] rs_w     = wr_data[`UVFR_RS_HI:`UVFR_RS_LO];
	// Delay bit 2 is dropped here, never refused
	wire logic [1:0] td_w     = wr_data[`UVFR_TD_HI-1:`UVFR_TD_LO];
	wire logic       rs_latch = (rs_w == `UVFR_RS_LATCH);
	wire logic       rs_hic   = (rs_w == `UVFR_RS_HICCUP);
	wire logic       bad_rsvd = wr_data[`UVFR_BIT_RSVD];
	wire logic       bad_rs   = !rs_latch && !rs_hic;
	wire logic       bad      = hit && (bad_rsvd || bad_rs);
	// A refused byte moves no field, so the old setup stays in force
	wire logic       good     = hit && !bad;
	wire logic [7:0] reg_v    = {1'b0, act_q, rs_q, 1'b0, td_q};

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			act_q <= 1'b1;
		end else if (good) begin
			act_q <= wr_act;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rs_q <= `UVFR_RS_LATCH;
		end else if (good) begin
			rs_q <= rs_w;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			td_q <= 2'h0;
		end else if (good) begin
			td_q <= td_w;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rd_data <= `UVFR_RESP_RESET;
		end else begin
			rd_data <= reg_v;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wr_nack <= 1'b0;
		end else begin
			wr_nack <= bad;
		end
	end

	// Set wins over a clear in the same cycle
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			invalid_data <= 1'b0;
		end else begin
			invalid_data <= bad | (invalid_data & ~clear_faults);
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			nvm_retry_bit <= 1'b0;
		end else begin
			nvm_retry_bit <= rs_q[2];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Delay selection
	logic [31:0] delay_cyc;
	always_comb begin
		unique case (td_q)
			2'h0: delay_cyc = `UVFR_US_CYC(`UVFR_TD0_US);
			2'h1: delay_cyc = `UVFR_US_CYC(`UVFR_TD1_US);
			2'h2: delay_cyc = `UVFR_US_CYC(`UVFR_TD2_US);
			2'h3: delay_cyc = `UVFR_US_CYC(`UVFR_TD3_US);
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Fault flags: a new fault beats a clear in the same cycle
	logic flag_q;
	logic pend_q;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= uv_now | (flag_q & ~clear_faults);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Response machine
	uvfr_state_type st_q, st_d;
	logic [31:0]    cnt_q, cnt_d;
	wire logic      delay_end  = (cnt_q + 32'h1 >= delay_cyc);
	wire logic      hiccup_end = (cnt_q + 32'h1 >= HICCUP_CYC);
	wire logic      rs_hiccup  = (rs_q == `UVFR_RS_HICCUP);
	// Pending covers a fault seen while ignoring; it keeps the delay
	// running after the level has gone, so the response is taken once
	wire logic      hold_on    = uv_now | pend_q;
	wire logic      trig       = act_q & hold_on;

	always_comb begin
		st_d  = st_q;
		cnt_d = 32'h0;
		unique case (st_q)
			UVFR_RUN: if (trig) st_d = UVFR_DELAY;
			UVFR_DELAY: begin
				if (!act_q) st_d = UVFR_RUN;
				else if (!hold_on)
					st_d = UVFR_RUN;
				else if (delay_end)
					st_d = rs_hiccup ? UVFR_WAIT : UVFR_OFF;
				else cnt_d = cnt_q + 32'h1;
			end
			UVFR_OFF: if (clear_faults || en_rise) st_d = UVFR_RUN;
			UVFR_WAIT: begin
				if (hiccup_end) st_d = UVFR_RUN;
				else cnt_d = cnt_q + 32'h1;
			end
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= UVFR_RUN;
		end else begin
			st_q <= st_d;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= 32'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Pending fault from ignore time, dropped once acted on or cleared
	wire logic resp_take = (st_q == UVFR_DELAY) &&
	                       ((st_d == UVFR_OFF) || (st_d == UVFR_WAIT));
	wire logic pend_set  = uv_now & ~act_q;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pend_q <= 1'b0;
		end else begin
			pend_q <= pend_set | (pend_q & ~clear_faults & ~resp_take);
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs
	wire logic run_next = (st_d == UVFR_RUN) || (st_d == UVFR_DELAY);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			convert_en <= 1'b1;
		end else begin
			convert_en <= run_next;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			status_byte_uv <= 1'b0;
		end else begin
			status_byte_uv <= flag_q;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			output_fault_warning_flag <= 1'b0;
		end else begin
			output_fault_warning_flag <= flag_q;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			undervoltage_fault_flag <= 1'b0;
		end else begin
			undervoltage_fault_flag <= flag_q;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			host_alert_pin_n <= 1'b1;
		end else begin
			host_alert_pin_n <= ~(flag_q | invalid_data);
		end
	end
endmodule

// ---- sim/uvfr_properties.sv ----
// Port assertions for the undervoltage response block.
// Assumes binding onto uvfr_core, whose port names match these inputs.
`timescale 1ns/1ps
module uvfr_props #(parameter int unsigned HICCUP_CYC = 50) (
	// Watched ports
	input wire logic       clock, arst_n, wr_strobe, clear_faults,
	input wire logic       ramp_done_raw, convert_en, wr_nack, enable_raw,
	input wire logic       undervoltage_fault_flag, status_byte_uv,
	input wire logic       output_fault_warning_flag, host_alert_pin_n,
	input wire logic [7:0] cmd_code, wr_data, rd_data
);
	logic [31:0] low_q;
	logic [2:0]  en_h_q;
	// Enable unchanged over the last samples: no restart can be underway
	wire en_quiet = (en_h_q == {3{enable_raw}});
	always_ff @(posedge clock or negedge arst_n)
		if (!arst_n) en_h_q <= 3'h0;
		else en_h_q <= {en_h_q[1:0], enable_raw};
	wire hit = wr_strobe && cmd_code == 8'h45;
	wire rs_ok = wr_data[5:3] == 3'h0 || wr_data[5:3] == 3'h7;
	wire bad = hit && (wr_data[7] || !rs_ok);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// Counts how long the converter has been held off
	always_ff @(posedge clock or negedge arst_n)
		if (!arst_n) low_q <= '0;
		else low_q <= convert_en ? '0 : low_q + 1;
	sequence s_good;
		hit && !bad;
	endsequence
	a_bit7_zero: assert property (!rd_data[7]) else $error("bit7");
	a_nack_bad: assert property (bad |=> wr_nack) else $error("nack");
	a_good_store: assert property (s_good |=> !wr_nack ##1
		rd_data == ($past(wr_data, 2) & 8'h7b)) else $error("store");
	a_bad_keep: assert property (bad |=> ##1 $stable(rd_data))
		else $error("keep");
	a_flags_tied: assert property (undervoltage_fault_flag == status_byte_uv
		&& status_byte_uv == output_fault_warning_flag) else $error("flags");
	a_alert_flag: assert property (undervoltage_fault_flag
		|-> !host_alert_pin_n) else $error("alert");
	a_ignore_run: assert property ($fell(convert_en) |-> rd_data[6])
		else $error("ignore");
	a_ramp_gate: assert property (!ramp_done_raw [*6]
		|-> !$rose(undervoltage_fault_flag)) else $error("ramp");
	a_hiccup_len: assert property ($rose(convert_en)
		&& rd_data[5:3] == 3'h7 |-> low_q >= HICCUP_CYC - 2) else $error("hic");
	a_latch_hold: assert property (rd_data[5:3] == 3'h0 && !convert_en
		&& !clear_faults && !$past(clear_faults) && en_quiet
		|=> !convert_en)
		else $error("latch");
endmodule
bind uvfr_core uvfr_props #(.HICCUP_CYC(HICCUP_CYC)) uvfr_props_inst (.*);

// ---- sim/uvfr_host.sv ----
// Host model: byte writes and fault clears toward the response block.
// Assumes a free clock; drives one nanosecond after each rising edge.
`timescale 1ns/1ps
module uvfr_host (
	// Host side
	input  wire logic clock,
	output logic [7:0] cmd_code, wr_data,
	output logic       wr_strobe, clear_faults
);
	initial begin
		cmd_code = 8'h00;
		wr_data = 8'h00;
		wr_strobe = 1'b0;
		clear_faults = 1'b0;
	end
	task wr(input logic [7:0] d);
		@(posedge clock);
		#1 cmd_code = 8'h45;
		wr_data = d;
		wr_strobe = 1'b1;
		@(posedge clock);
		#1 wr_strobe = 1'b0;
		wr_data = ~d; // Released bus never shows a stale byte
	endtask
	task clr;
		@(posedge clock);
		#1 clear_faults = 1'b1;
		@(posedge clock);
		#1 clear_faults = 1'b0;
	endtask
endmodule

// ---- sim/tb_uvfr_core.sv ----
// Self-checking bench for the undervoltage response block.
// Assumes the host model and a short hiccup count of 50 cycles.
`timescale 1ns/1ps
module tb_uvfr_core;
	logic clock, arst_n, uv_raw, ramp_done_raw;
	logic enable_raw, wr_strobe, clear_faults, wr_nack, invalid_data;
	logic convert_en, status_byte_uv, output_fault_warning_flag;
	logic undervoltage_fault_flag, host_alert_pin_n, nvm_retry_bit;
	logic [7:0] cmd_code, wr_data, rd_data;
	int num_errors, cmp_count;
	always #5 clock = ~clock;
	uvfr_host uvfr_host_inst (.*);
	uvfr_core #(.HICCUP_CYC(50)) uvfr_core_inst (.*);
	task chk(input logic [15:0] s, e);
		cmp_count++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %0t %h %h", $time, s, e);
		end
	endtask
	task results;
		if (num_errors == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////
	task t_regs;
		chk(rd_data, 8'h40);
		uvfr_host_inst.wr(8'h7f);
		cyc(2);
		chk(rd_data, 8'h7b);
		chk(nvm_retry_bit, 1'b1);
		uvfr_host_inst.wr(8'hc0);
		chk(wr_nack, 1'b1);
		uvfr_host_inst.wr(8'h68);
		chk(wr_nack, 1'b1);
		cyc(2);
		chk({invalid_data, host_alert_pin_n, rd_data}, 10'h27b);
		uvfr_host_inst.clr;
		uvfr_host_inst.wr(8'h00);
		cyc(2);
		chk(invalid_data, 1'b0);
	endtask
	task t_ignore;
		uv_raw = 1'b1;
		cyc(400);
		chk(convert_en, 1'b1);
		chk({status_byte_uv, output_fault_warning_flag,
			undervoltage_fault_flag, host_alert_pin_n}, 4'he);
		uv_raw = 1'b0;
		uvfr_host_inst.wr(8'h40);
		cyc(260);
		chk(convert_en, 1'b0);
		cyc(300);
		chk(convert_en, 1'b0);
		uvfr_host_inst.clr;
		cyc(5);
		chk({convert_en, undervoltage_fault_flag}, 2'b10);
	endtask
	task t_glitch;
		repeat (2) begin
			uv_raw = 1'b1;
			cyc(150);
			uv_raw = 1'b0;
			cyc(10);
		end
		cyc(100);
		chk(convert_en, 1'b1);
		uvfr_host_inst.clr;
	endtask
	task t_hiccup;
		uvfr_host_inst.wr(8'h79);
		uv_raw = 1'b1;
		cyc(1500);
		chk(convert_en, 1'b1);
		cyc(130);
		chk(convert_en, 1'b0);
		uv_raw = 1'b0;
		cyc(60);
		chk(convert_en, 1'b1);
	endtask
	task t_enable;
		uvfr_host_inst.wr(8'h40);
		uv_raw = 1'b1;
		cyc(250);
		chk(convert_en, 1'b0);
		uv_raw = 1'b0;
		enable_raw = 1'b0;
		cyc(5);
		chk(convert_en, 1'b0);
		enable_raw = 1'b1;
		cyc(5);
		chk(convert_en, 1'b1);
	endtask
	initial begin
		#200000;
		num_errors++;
		results;
	end
	initial begin
		clock = 1'b0;
		arst_n = 1'b0;
		uv_raw = 1'b0;
		ramp_done_raw = 1'b0;
		enable_raw = 1'b1;
		cyc(2);
		arst_n = 1'b1;
		uv_raw = 1'b1;
		cyc(300);
		chk(undervoltage_fault_flag, 1'b0);
		uv_raw = 1'b0;
		ramp_done_raw = 1'b1;
		cyc(5);
		t_regs;
		t_ignore;
		t_glitch;
		t_hiccup;
		t_enable;
		results;
	end
endmodule
